/* File: verilog/idg_defines.svh */
// Offsets, field positions, reset values and limits of the request gating block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef IDG_DEFINES_SVH
`define IDG_DEFINES_SVH

// ==========================================================================
// Register map, per logical device (8-bit address: device in [7:4])
`define IDG_DEV_SER        4'h0
`define IDG_DEV_PAR        4'h1
`define IDG_REG_ACT        3'h0
`define IDG_REG_BASE_LO    3'h1
`define IDG_REG_BASE_HI    3'h2
`define IDG_REG_IRQSEL     3'h3
`define IDG_REG_DMASEL     3'h4
`define IDG_REG_DEVA       3'h5
`define IDG_REG_DEVB       3'h6
`define IDG_REG_DEVC       3'h7

// ==========================================================================
// Global registers
`define IDG_REG_STAT       8'h20
`define IDG_REG_CLR        8'h21
`define IDG_REG_EN         8'h22
`define IDG_REG_LIVE       8'h23

// ==========================================================================
// Field positions
`define IDG_ACT_BIT        0
`define IDG_MODEM_GATE_BIT 2
`define IDG_ENGINE_DMA_BIT 0
`define IDG_PORT_IRQ_BIT   4
`define IDG_ECR_DMA_BIT    3
`define IDG_ECR_MODE_LSB   5
`define IDG_PMODE_LSB      0

// ==========================================================================
// Reset values and limits
`define IDG_RST_REG        8'h00
`define IDG_RST_DMASEL     8'h04
`define IDG_IRQSEL_NONE    4'h0
`define IDG_DMASEL_NONE    3'h4
`define IDG_BASE_MIN       16'h0100
`define IDG_BASE_MAX       16'h0FF8

`endif

/* File: verilog/idg_pkg.sv */
// Types shared by the request gating block.
// Assumes idg_defines.svh is compiled alongside.
`default_nettype none

package idg_pkg;

  // ========================================================================
  // Parallel port operating modes
  typedef enum logic [1:0] {
    IDG_STANDARD_PRINTER_MODE = 2'h0,
    IDG_ENHANCED_PRINTER_MODE = 2'h1,
    IDG_EXT_CAPABILITY_MODE   = 2'h2
  } idg_pmode_e;

  // Mode field of the extended control register
  typedef enum logic [2:0] {
    IDG_ECR_PRINTER  = 3'h0,
    IDG_ECR_STANDARD = 3'h1,
    IDG_ECR_FIFO     = 3'h2,
    IDG_ECR_EXTCAP   = 3'h3,
    IDG_ECR_ENHANCED = 3'h4,
    IDG_ECR_RES     = 3'h5,
    IDG_ECR_TEST    = 3'h6,
    IDG_ECR_CONFIG  = 3'h7
  } idg_ecr_mode_e;

  // ========================================================================
  // Whole state of the top module
  typedef struct packed {
    logic [1:0][7:0][7:0] cfg;
    logic [7:0]           stat;
    logic [7:0]           en;
    logic [7:0]           rdData;
    logic [15:0]          irqOut;
    logic [15:0]          irqOe;
    logic [3:0]           dmaOut;
    logic [3:0]           prevLive;
    logic [3:0]           prevBlocked;
  } idg_state_s;

endpackage : idg_pkg

`default_nettype wire

/* File: verilog/idg_gate_if.sv */
// Carrier between the top and a device-level gate: device registers out, enables back.
// Assumes one instance per logical device.
`timescale 1ns/1ps
`default_nettype none

interface idg_gate_if;
  logic [7:0] regA;
  logic [7:0] regB;
  logic [7:0] regC;
  logic       irqEn;
  logic       dmaOk;

  modport cfg  (output regA, output regB, output regC, input irqEn, input dmaOk);
  modport gate (input regA, input regB, input regC, output irqEn, output dmaOk);
endinterface : idg_gate_if

`default_nettype wire

/* File: verilog/idg_ser_gate.sv */
// Device-level gate of the second serial port.
// Assumes regA is the modem control register and regB the engine config register B.
`timescale 1ns/1ps
`default_nettype none
`include "idg_defines.svh"

module idg_ser_gate
  import idg_pkg::*;
(
  // Device registers and enables
  idg_gate_if.gate gif
);

  // ========================================================================
  // Enables
  always_comb begin
    gif.irqEn = gif.regA[`IDG_MODEM_GATE_BIT];
    gif.dmaOk = gif.regB[`IDG_ENGINE_DMA_BIT];
  end

endmodule : idg_ser_gate

`default_nettype wire

/* File: verilog/idg_par_gate.sv */
// Device-level gate of the parallel port.
// Assumes regA is the control port, regB the extended control register, regC the mode.
`timescale 1ns/1ps
`default_nettype none
`include "idg_defines.svh"

module idg_par_gate
  import idg_pkg::*;
(
  // Device registers and enables
  idg_gate_if.gate gif
);

  idg_pmode_e    pmode;
  idg_ecr_mode_e ecrMode;
  logic          portIrqOn;

  // ========================================================================
  // Enables
  always_comb begin
    pmode   = idg_pmode_e'(gif.regC[`IDG_PMODE_LSB +: 2]);
    ecrMode = idg_ecr_mode_e'(gif.regB[`IDG_ECR_MODE_LSB +: 3]);
    portIrqOn = gif.regA[`IDG_PORT_IRQ_BIT];
    gif.irqEn = 1'b0;
    gif.dmaOk = 1'b0;
    if (pmode == IDG_EXT_CAPABILITY_MODE) begin
      gif.dmaOk = gif.regB[`IDG_ECR_DMA_BIT];
      unique case (ecrMode)
        IDG_ECR_FIFO, IDG_ECR_EXTCAP, IDG_ECR_TEST: begin
          gif.irqEn = 1'b1;
        end
        IDG_ECR_PRINTER, IDG_ECR_STANDARD, IDG_ECR_ENHANCED, IDG_ECR_RES, IDG_ECR_CONFIG: begin
          gif.irqEn = portIrqOn;
        end
      endcase
    end else begin
      // Printer modes have no DMA path; also covers the unused mode code
      gif.irqEn = portIrqOn;
    end
  end

endmodule : idg_par_gate

`default_nettype wire

/* File: verilog/idg_top.sv */
// Interrupt and DMA request gating for the second serial port and the parallel port.
// Assumes raw requests come from logic on clk_sys; pins are resolved outside.
//
// What this block does
// - The serial port interrupt floats whenever the modem gate bit of its modem control register is 0.
// - The serial port DMA channel is off while engine config register B bit 0 is 0 and on when it is 1.
// - In standard and enhanced printer modes the parallel interrupt floats while its enable bit D4 is 0.
// - In extended capability operation parallel DMA is gated at device level only by the extended DMA enable bit, whatever the mode field.
// - Parallel interrupt follows its enable bit in modes 000,001,100,101,111 and is always on in 010,011,110.
// - A device's own disabling bits each suppress one output: one its interrupt output, the other its DMA requests.
// - Deactivation, a base address out of range, interrupt select 0 or DMA select 4 also suppress them.
// - DMA select values 0 to 3 pick channels 0 to 3 and values 4 to 7 mean no channel.
`timescale 1ns/1ps
`default_nettype none
`include "idg_defines.svh"

module idg_top
  import idg_pkg::*;
#(
  parameter int IRQ_LINES = 15,
  parameter int DMA_CHANS = 4
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  // Raw requests from the port logic
  input  wire logic        serIrqReq,
  input  wire logic        serDmaReq,
  input  wire logic        parIrqReq,
  input  wire logic        parDmaReq,
  // Interrupt pins, driven while Oe is high
  output logic      [15:0] irqPinOut,
  output logic      [15:0] irqPinOe,
  // DMA request lines per channel
  output logic      [3:0]  dmaReqLine,
  // Block interrupt
  output logic             irq
);

  // ========================================================================
  // Elaboration checks
  generate
    if (IRQ_LINES < 1 || IRQ_LINES > 15) begin : gBadIrq
      $error("IRQ_LINES must be 1 to 15");
    end
    if (DMA_CHANS < 1 || DMA_CHANS > 4) begin : gBadDma
      $error("DMA_CHANS must be 1 to 4");
    end
  endgenerate

  localparam int NUM_DEV = 2;

  // ========================================================================
  // Reset image
  function automatic idg_state_s rstState();
    idg_state_s s;
    s = '0;
    for (int d = 0; d < NUM_DEV; d++) begin
      for (int r = 0; r < 8; r++) begin
        s.cfg[d][r] = `IDG_RST_REG;
      end
      s.cfg[d][`IDG_REG_DMASEL] = `IDG_RST_DMASEL;
    end
    s.en = `IDG_RST_REG;
    return s;
  endfunction : rstState

  idg_state_s s_r;
  idg_state_s s_nxt;

  // ========================================================================
  // Device-level gates
  idg_gate_if serIf ();
  idg_gate_if parIf ();

  assign serIf.regA = s_r.cfg[0][`IDG_REG_DEVA];
  assign serIf.regB = s_r.cfg[0][`IDG_REG_DEVB];
  assign serIf.regC = s_r.cfg[0][`IDG_REG_DEVC];
  assign parIf.regA = s_r.cfg[1][`IDG_REG_DEVA];
  assign parIf.regB = s_r.cfg[1][`IDG_REG_DEVB];
  assign parIf.regC = s_r.cfg[1][`IDG_REG_DEVC];

  idg_ser_gate uSer (
    .gif (serIf.gate)
  );

  idg_par_gate uPar (
    .gif (parIf.gate)
  );

  // ========================================================================
  // Next state
  logic [NUM_DEV-1:0] devIrqEn;
  logic [NUM_DEV-1:0] devDmaEn;
  logic [NUM_DEV-1:0] rawIrq;
  logic [NUM_DEV-1:0] rawDma;

  assign devIrqEn = {parIf.irqEn, serIf.irqEn};
  assign devDmaEn = {parIf.dmaOk, serIf.dmaOk};
  assign rawIrq   = {parIrqReq, serIrqReq};
  assign rawDma   = {parDmaReq, serDmaReq};

  always_comb begin
    logic [NUM_DEV-1:0] irqDrive;
    logic [NUM_DEV-1:0] dmaDrive;
    logic [3:0]         live;
    logic [3:0]         blocked;
    logic [7:0]         setMask;
    logic [7:0]         clrMask;
    logic [15:0]        base;
    logic               baseOk;
    logic               act;
    logic [3:0]         irqSel;
    logic [2:0]         dmaSel;
    logic [2:0]         regIdx;
    logic [3:0]         devIdx;
    irqDrive = '0;
    dmaDrive = '0;
    live     = '0;
    blocked  = '0;
    setMask  = '0;
    clrMask  = '0;
    base     = '0;
    baseOk   = 1'b0;
    act      = 1'b0;
    irqSel   = '0;
    dmaSel   = '0;
    regIdx   = regAddr[2:0];
    devIdx   = regAddr[7:4];
    s_nxt    = s_r;

    // Configuration-level and device-level enables combine as one AND
    for (int d = 0; d < NUM_DEV; d++) begin
      base   = {s_r.cfg[d][`IDG_REG_BASE_HI], s_r.cfg[d][`IDG_REG_BASE_LO]};
      baseOk = (base >= `IDG_BASE_MIN) && (base <= `IDG_BASE_MAX);
      act    = s_r.cfg[d][`IDG_REG_ACT][`IDG_ACT_BIT];
      irqSel = s_r.cfg[d][`IDG_REG_IRQSEL][3:0];
      dmaSel = s_r.cfg[d][`IDG_REG_DMASEL][2:0];
      irqDrive[d] = act && baseOk && (irqSel != `IDG_IRQSEL_NONE)
                    && devIrqEn[d];
      dmaDrive[d] = act && baseOk && (dmaSel < `IDG_DMASEL_NONE)
                    && devDmaEn[d];
      live[2*d]      = irqDrive[d] && rawIrq[d];
      live[2*d+1]    = dmaDrive[d] && rawDma[d];
      blocked[2*d]   = !irqDrive[d] && rawIrq[d];
      blocked[2*d+1] = !dmaDrive[d] && rawDma[d];
    end

    // Pins: a line floats unless some enabled device selects it
    s_nxt.irqOut = '0;
    s_nxt.irqOe  = '0;
    s_nxt.dmaOut = '0;
    for (int d = 0; d < NUM_DEV; d++) begin
      irqSel = s_r.cfg[d][`IDG_REG_IRQSEL][3:0];
      dmaSel = s_r.cfg[d][`IDG_REG_DMASEL][2:0];
      for (int n = 1; n <= IRQ_LINES; n++) begin
        if (irqDrive[d] && irqSel == 4'(n)) begin
          s_nxt.irqOe[n]  = 1'b1;
          s_nxt.irqOut[n] = s_nxt.irqOut[n] | rawIrq[d];
        end
      end
      for (int c = 0; c < DMA_CHANS; c++) begin
        if (dmaDrive[d] && rawDma[d] && dmaSel == 3'(c)) begin
          s_nxt.dmaOut[c] = 1'b1;
        end
      end
    end

    // Register writes
    if (regWr) begin
      if (devIdx < 4'(NUM_DEV)) begin
        if (regIdx == `IDG_REG_ACT) begin
          s_nxt.cfg[devIdx[0]][regIdx] = {7'h00, regWrData[`IDG_ACT_BIT]};
        end else if (regIdx == `IDG_REG_IRQSEL) begin
          s_nxt.cfg[devIdx[0]][regIdx] = {4'h0, regWrData[3:0]};
        end else if (regIdx == `IDG_REG_DMASEL) begin
          s_nxt.cfg[devIdx[0]][regIdx] = {5'h00, regWrData[2:0]};
        end else begin
          s_nxt.cfg[devIdx[0]][regIdx] = regWrData;
        end
      end else if (regAddr == `IDG_REG_CLR) begin
        clrMask = regWrData;
      end else if (regAddr == `IDG_REG_EN) begin
        s_nxt.en = regWrData;
      end
    end

    // Sticky events: delivered request rising, refused request rising
    setMask = {blocked & ~s_r.prevBlocked, live & ~s_r.prevLive};
    s_nxt.stat        = (s_r.stat & ~clrMask) | setMask; // Set beats a same-cycle clear
    s_nxt.prevLive    = live;
    s_nxt.prevBlocked = blocked;

    // Read data stands for exactly the cycle after the strobe
    s_nxt.rdData = 8'h00;
    if (regRd) begin
      if (devIdx < 4'(NUM_DEV)) begin
        s_nxt.rdData = s_r.cfg[devIdx[0]][regIdx];
      end else if (regAddr == `IDG_REG_STAT) begin
        s_nxt.rdData = s_r.stat;
      end else if (regAddr == `IDG_REG_EN) begin
        s_nxt.rdData = s_r.en;
      end else if (regAddr == `IDG_REG_LIVE) begin
        s_nxt.rdData = {dmaDrive[1], irqDrive[1], dmaDrive[0], irqDrive[0], live};
      end
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= rstState();
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign regRdData  = s_r.rdData;
  assign irqPinOut  = s_r.irqOut;
  assign irqPinOe   = s_r.irqOe;
  assign dmaReqLine = s_r.dmaOut;
  assign irq        = |(s_r.stat & s_r.en);

endmodule : idg_top

`default_nettype wire

/* File: verif/idg_top_monitor.sv */
// Concurrent checks on the ports of the request gating top.
// Assumes a bind from the bench; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module idg_top_monitor #(
  parameter int IRQ_LINES = 15,
  parameter int DMA_CHANS = 4
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  // Raw requests
  input wire logic        serIrqReq,
  input wire logic        serDmaReq,
  input wire logic        parIrqReq,
  input wire logic        parDmaReq,
  // Gated outputs
  input wire logic [15:0] irqPinOut,
  input wire logic [15:0] irqPinOe,
  input wire logic [3:0]  dmaReqLine,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Register port
  chk_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");
  chk_clr_read_zero: assert property (regRd && regAddr == 8'h21 |=> regRdData == 8'h00)
    else $error("clear register read not zero");
  chk_unmapped_zero: assert property (regRd && regAddr[7:4] > 4'h2 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");

  // ==========================================================================
  // Gating
  chk_line0_unused: assert property (irqPinOe[0] == 1'b0 && irqPinOut[0] == 1'b0)
    else $error("line 0 driven");
  chk_dma_needs_req: assert property (!(serDmaReq || parDmaReq) |=> dmaReqLine == 4'h0)
    else $error("dma line without request");
  chk_irq_needs_req: assert property (!(serIrqReq || parIrqReq) |=> (irqPinOut & irqPinOe) == 16'h0000)
    else $error("irq line high without request");
  // Config and raw level steady for two edges leave no room for a change
  chk_dma_steady: assert property ((!regWr && $stable({serDmaReq, parDmaReq}))[*2] |=> $stable(dmaReqLine))
    else $error("dma line moved with no cause");
  chk_irq_rise_cause: assert property ($rose(irq) |-> $past(regWr) || $past(serIrqReq || parIrqReq || serDmaReq || parDmaReq))
    else $error("block interrupt rose with no cause");
  chk_irq_fall_cause: assert property ($fell(irq) |-> $past(regWr))
    else $error("block interrupt fell with no write");
endmodule : idg_top_monitor

`default_nettype wire

/* File: verif/idg_host_model.sv */
// Host side of the interrupt lines.
// Assumes lines carry a pull-down on the board.
`timescale 1ns/1ps
`default_nettype none

module idg_host_model (
  // Pins from the device
  input  wire logic [15:0] irqPinOut,
  input  wire logic [15:0] irqPinOe,
  // Level the host sees
  output logic      [15:0] irqLevel
);
  // Floating lines fall to the pull, never keep the last value
  assign irqLevel = irqPinOut & irqPinOe;
endmodule : idg_host_model

`default_nettype wire

/* File: verif/test_idg_top.sv */
// Self-checking bench of the request gating top.
// Assumes the design files and the monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_idg_top;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        serIrqReq = 1'b0;
  logic        serDmaReq = 1'b0;
  logic        parIrqReq = 1'b0;
  logic        parDmaReq = 1'b0;
  logic [7:0]  regRdData;
  logic [15:0] irqPinOut;
  logic [15:0] irqPinOe;
  logic [15:0] irqLevel;
  logic [3:0]  dmaReqLine;
  logic        irq;
  int          errCount = 0;
  int          totalChecks = 0;

  always #50 clk_sys = ~clk_sys;

  idg_top i_idg_top (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .serIrqReq(serIrqReq), .serDmaReq(serDmaReq),
    .parIrqReq(parIrqReq), .parDmaReq(parDmaReq), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe),
    .dmaReqLine(dmaReqLine), .irq(irq));
  idg_host_model i_idg_host_model (.irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .irqLevel(irqLevel));

  // ==========================================================================
  // Shared tasks
  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    cmp("regRdData", 16'(exp), 16'(regRdData));
    @(posedge clk_sys);
  endtask : rd

  // Lets the registered outputs follow, then judges the pins
  task automatic pins(input logic [15:0] oe, input logic [3:0] dma);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp("irqPinOe", oe, irqPinOe);
    cmp("irqLevel", oe, irqLevel);
    cmp("dmaReqLine", 16'(dma), 16'(dmaReqLine));
  endtask : pins

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    pins(16'h0000, 4'h0);
    rd(8'h04, 8'h04);
    rd(8'h14, 8'h04);
    rd(8'h03, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h22, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h30, 8'h00);
  endtask : t_reset

  task automatic t_serial;
    wr(8'h00, 8'h01);
    wr(8'h02, 8'h03);
    wr(8'h03, 8'h05);
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h04);
    wr(8'h06, 8'h01);
    serIrqReq <= 1'b1;
    serDmaReq <= 1'b1;
    pins(16'h0020, 4'h2);
    for (int s = 0; s < 8; s++) begin
      wr(8'h04, 8'(s));
      pins(16'h0020, (s < 4) ? 4'(1 << s) : 4'h0);
    end
    wr(8'h04, 8'h02);
    wr(8'h05, 8'h00);
    pins(16'h0000, 4'h4);
    wr(8'h05, 8'h04);
    wr(8'h06, 8'h00);
    pins(16'h0020, 4'h0);
    wr(8'h06, 8'h01);
    wr(8'h03, 8'h00);
    pins(16'h0000, 4'h4);
    wr(8'h03, 8'h05);
    wr(8'h02, 8'h0F);
    wr(8'h01, 8'hF9);
    pins(16'h0000, 4'h0);
    wr(8'h01, 8'hF8);
    pins(16'h0020, 4'h4);
    wr(8'h00, 8'h00);
    pins(16'h0000, 4'h0);
    serIrqReq <= 1'b0;
    serDmaReq <= 1'b0;
  endtask : t_serial

  task automatic t_parallel;
    wr(8'h10, 8'h01);
    wr(8'h11, 8'h78);
    wr(8'h12, 8'h03);
    wr(8'h13, 8'h07);
    wr(8'h14, 8'h03);
    wr(8'h17, 8'h02);
    parIrqReq <= 1'b1;
    parDmaReq <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 4; k++) begin
        wr(8'h15, k[0] ? 8'h10 : 8'h00);
        wr(8'h16, {3'(m), 1'b0, k[1], 3'h0});
        pins((k[0] || m == 2 || m == 3 || m == 6) ? 16'h0080 : 16'h0000, k[1] ? 4'h8 : 4'h0);
      end
    end
    wr(8'h14, 8'h04);
    pins(16'h0080, 4'h0);
    wr(8'h14, 8'h03);
    wr(8'h16, 8'h68);
    for (int p = 0; p < 2; p++) begin
      wr(8'h17, 8'(p));
      wr(8'h15, 8'h00);
      pins(16'h0000, 4'h0);
      wr(8'h15, 8'h10);
      pins(16'h0080, 4'h0);
    end
  endtask : t_parallel

  task automatic t_status;
    parIrqReq <= 1'b0;
    parDmaReq <= 1'b0;
    wr(8'h21, 8'hFF);
    rd(8'h20, 8'h00);
    wr(8'h22, 8'h04);
    parIrqReq <= 1'b1;
    pins(16'h0080, 4'h0);
    cmp("irq", 16'h0001, 16'(irq));
    rd(8'h20, 8'h04);
    rd(8'h23, 8'h44);
    wr(8'h22, 8'h00);
    cmp("irq", 16'h0000, 16'(irq));
    wr(8'h22, 8'h04);
    wr(8'h21, 8'h04);
    rd(8'h20, 8'h00);
    cmp("irq", 16'h0000, 16'(irq));
    // Gate off, clear what that raised, then a fresh rising request is refused
    wr(8'h15, 8'h00);
    parIrqReq <= 1'b0;
    pins(16'h0000, 4'h0);
    wr(8'h21, 8'hFF);
    rd(8'h20, 8'h00);
    parIrqReq <= 1'b1;
    pins(16'h0000, 4'h0);
    rd(8'h20, 8'h40);
    cmp("irq", 16'h0000, 16'(irq));
  endtask : t_status

  // ==========================================================================
  // Main sequence and hang guard
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_serial;
    t_parallel;
    t_status;
    conclude;
  end

  initial begin
    #2000000;
    errCount++;
    conclude;
  end
endmodule : test_idg_top

bind idg_top idg_top_monitor #(.IRQ_LINES(IRQ_LINES), .DMA_CHANS(DMA_CHANS)) i_idg_top_monitor (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .serIrqReq(serIrqReq), .serDmaReq(serDmaReq), .parIrqReq(parIrqReq),
  .parDmaReq(parDmaReq), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .dmaReqLine(dmaReqLine), .irq(irq));

`default_nettype wire
